// file: reload_timer_pkg.sv
// Constants, register map and types of the reloadable capture/PWM timer
// Operation
// - Polarity clear: PWM high fraction is (reload minus pwm) over reload.
// - Polarity set: PWM high fraction is pwm over reload.
// - Capture mode copies the count into the PWM high and low bytes.
// - Polarity bit picks rising or falling input edge for capture.
// - Capture mode counts the prescaled system clock, not the input pin.
// - Capture raises interrupt, keeps counting, sets the capture-cause flag.
// - Reaching reload in capture mode interrupts, counts on, clears the flag.
// - Prescale field bits 5:3 divides input clock by two to the field.
// - Prescaler returns to its initial state whenever the timer is disabled.
// - Mode is four bits: control 0 bit 7 over control 1 bits 2:0.
// - Mode codes one-shot, continuous, counter, PWM, capture, compare, others.
// - Enabled: reading count high latches low byte; low reads return latch.
// - Disabled: reading count low returns the live counter low byte.
// - Count byte writes load the counter next edge; counting continues.
package reload_timer_pkg;
   // Register addresses (byte wide registers, one per address)
   localparam logic [3:0] ADDR_CTL0 = 4'h0;
   localparam logic [3:0] ADDR_CTL1 = 4'h1;
   localparam logic [3:0] ADDR_CNT_HI = 4'h2;
   localparam logic [3:0] ADDR_CNT_LO = 4'h3;
   localparam logic [3:0] ADDR_RLD_HI = 4'h4;
   localparam logic [3:0] ADDR_RLD_LO = 4'h5;
   localparam logic [3:0] ADDR_PWM_HI = 4'h6;
   localparam logic [3:0] ADDR_PWM_LO = 4'h7;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
   // Field positions
   localparam int CTL0_MODE_HI_BIT = 7;
   localparam int CTL0_CAP_CAUSE_BIT = 4;
   localparam int CTL1_ENABLE_BIT = 7;
   localparam int CTL1_POL_BIT = 6;
   localparam int CTL1_PRESCALE_FIELD_MSB = 5;
   localparam int CTL1_PRESCALE_FIELD_LSB = 3;
   localparam int CTL1_MODE_MSB = 2;
   localparam int IRQ_RELOAD_BIT = 0;
   localparam int IRQ_CAPTURE_BIT = 1;
   // Reset values
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] RLD_RESET = 16'hFFFF;
   localparam logic [15:0] PWM_RESET = 16'h0000;
   localparam logic [15:0] CNT_RESTART = 16'h0001;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // Mode codes
   typedef enum logic [3:0] {
      MODE_ONE_SHOT = 4'h0,
      MODE_CONTINUOUS = 4'h1,
      MODE_COUNTER = 4'h2,
      MODE_PWM_SINGLE = 4'h3,
      MODE_CAPTURE = 4'h4,
      MODE_COMPARE = 4'h5,
      MODE_CAP_CMP = 4'h7,
      MODE_PWM_DUAL = 4'h8,
      MODE_CAP_RESTART = 4'h9,
      MODE_CMP_COUNTER = 4'hA
   } timer_mode_t;
endpackage

// file: reload_timer.sv
// Reloadable 16-bit timer with prescaler, PWM output and input capture
`timescale 1ns/100ps
`default_nettype none
module reload_timer
   import reload_timer_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic timer_in_i,
   output logic timer_out_o,
   output logic irq_o
);
   logic [7:0] ctl0_q;
   logic [7:0] ctl1_q;
   logic [15:0] cnt_q;
   logic [15:0] rld_q;
   logic [15:0] pwm_q;
   logic [7:0] hold_q;
   logic [6:0] pre_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic [7:0] rdata_q;
   logic out_q;
   logic in_s1_q;
   logic in_s2_q;
   logic in_prev_q;

   // Control field decode
   wire enable = ctl1_q[CTL1_ENABLE_BIT];
   wire pol = ctl1_q[CTL1_POL_BIT];
   wire [2:0] prescale_field = ctl1_q[CTL1_PRESCALE_FIELD_MSB:CTL1_PRESCALE_FIELD_LSB];
   wire [3:0] mode = {ctl0_q[CTL0_MODE_HI_BIT], ctl1_q[CTL1_MODE_MSB:0]};
   // decoded mode codes; other codes only count
   wire is_capture = (mode == MODE_CAPTURE);
   wire is_pwm = (mode == MODE_PWM_SINGLE);

   // Register write decode
   wire wr_ctl0 = wr_i && (addr_i == ADDR_CTL0);
   wire wr_ctl1 = wr_i && (addr_i == ADDR_CTL1);
   wire wr_cnt_hi = wr_i && (addr_i == ADDR_CNT_HI);
   wire wr_cnt_lo = wr_i && (addr_i == ADDR_CNT_LO);
   wire wr_rld_hi = wr_i && (addr_i == ADDR_RLD_HI);
   wire wr_rld_lo = wr_i && (addr_i == ADDR_RLD_LO);
   wire wr_pwm_hi = wr_i && (addr_i == ADDR_PWM_HI);
   wire wr_pwm_lo = wr_i && (addr_i == ADDR_PWM_LO);
   wire wr_stat = wr_i && (addr_i == ADDR_IRQ_STAT);
   wire wr_mask = wr_i && (addr_i == ADDR_IRQ_MASK);
   wire rd_cnt_hi = rd_i && (addr_i == ADDR_CNT_HI);

   // tick when the low prescale_field bits of the prescaler are all ones
   wire [6:0] pre_mask = 7'((8'h01 << prescale_field) - 8'h01);
   wire tick = enable && ((pre_q & pre_mask) == pre_mask);
   wire at_reload = (cnt_q == rld_q);
   wire reload_evt = tick && at_reload;

   // edge polarity follows the output polarity bit
   wire rise = in_s2_q && !in_prev_q;
   wire fall = !in_s2_q && in_prev_q;
   // capture only while enabled in capture mode
   wire cap_evt = enable && is_capture && (pol ? rise : fall);

   // Input pin synchroniser, first stage read only by the second
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         in_s1_q <= 1'b0;
         in_s2_q <= 1'b0;
         in_prev_q <= 1'b0;
      end else begin
         in_s1_q <= timer_in_i;
         in_s2_q <= in_s1_q;
         in_prev_q <= in_s2_q;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i || !enable) begin
         pre_q <= 7'h00;
      end else begin
         pre_q <= pre_q + 7'h01;
      end
   end

   // Control registers; hardware flag update wins over software write
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctl0_q <= CTL_RESET;
         ctl1_q <= CTL_RESET;
      end else begin
         if (wr_ctl0) begin
            ctl0_q <= wdata_i;
         end
         if (wr_ctl1) begin
            ctl1_q <= wdata_i;
         end
         if (cap_evt) begin
            ctl0_q[CTL0_CAP_CAUSE_BIT] <= 1'b1;
         end else if (reload_evt && is_capture) begin
            ctl0_q[CTL0_CAP_CAUSE_BIT] <= 1'b0;
         end
      end
   end

   // counter runs on prescaled system clock; byte loads win
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cnt_q <= CNT_RESET;
      end else if (wr_cnt_hi || wr_cnt_lo) begin
         if (wr_cnt_hi) begin
            cnt_q[15:8] <= wdata_i;
         end else begin
            cnt_q[7:0] <= wdata_i;
         end
      end else if (reload_evt) begin
         cnt_q <= CNT_RESTART;
      end else if (tick) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Reload and PWM/capture registers
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rld_q <= RLD_RESET;
         pwm_q <= PWM_RESET;
      end else begin
         if (wr_rld_hi) begin
            rld_q[15:8] <= wdata_i;
         end
         if (wr_rld_lo) begin
            rld_q[7:0] <= wdata_i;
         end
         if (cap_evt) begin
            pwm_q <= cnt_q;
         end else if (wr_pwm_hi) begin
            pwm_q[15:8] <= wdata_i;
         end else if (wr_pwm_lo) begin
            pwm_q[7:0] <= wdata_i;
         end
      end
   end

   // high byte read latches low byte while enabled
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         hold_q <= 8'h00;
      end else if (rd_cnt_hi && enable) begin
         hold_q <= cnt_q[7:0];
      end
   end

   // PWM output; the count runs 0001 to reload, so an inclusive
   // compare gives exactly pwm high cycles per period with polarity set
   wire below_pwm = (cnt_q <= pwm_q);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         out_q <= 1'b0;
      end else if (enable && is_pwm) begin
         out_q <= pol ? below_pwm : !below_pwm;
      end else begin
         out_q <= pol;
      end
   end

   // Interrupt status: set wins over write-one-to-clear
   wire [1:0] evt = {cap_evt, reload_evt};
   wire [1:0] clr = wr_stat ? wdata_i[1:0] : 2'h0;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         stat_q <= IRQ_RESET;
         mask_q <= IRQ_RESET;
      end else begin
         stat_q <= (stat_q & ~clr) | evt;
         if (wr_mask) begin
            mask_q <= wdata_i[1:0];
         end
      end
   end

   // Read multiplexer; live low byte when disabled
   wire [7:0] lo_view = enable ? hold_q : cnt_q[7:0];
   logic [7:0] rsel;
   always_comb begin
      case (addr_i)
         ADDR_CTL0: rsel = ctl0_q;
         ADDR_CTL1: rsel = ctl1_q;
         ADDR_CNT_HI: rsel = cnt_q[15:8];
         ADDR_CNT_LO: rsel = lo_view;
         ADDR_RLD_HI: rsel = rld_q[15:8];
         ADDR_RLD_LO: rsel = rld_q[7:0];
         ADDR_PWM_HI: rsel = pwm_q[15:8];
         ADDR_PWM_LO: rsel = pwm_q[7:0];
         ADDR_IRQ_STAT: rsel = {6'h00, stat_q};
         ADDR_IRQ_MASK: rsel = {6'h00, mask_q};
         default: rsel = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_i ? rsel : 8'h00;
      end
   end

   assign rdata_o = rdata_q;
   assign timer_out_o = out_q;
   assign irq_o = |(stat_q & mask_q);

   // Assertions
   a_capture_copy: assert property (@(posedge core_clk_i) disable iff (srst_i)
      cap_evt && !wr_cnt_hi |=> pwm_q == $past(cnt_q))
      else $error("capture did not copy count");
   a_capture_edge: assert property (@(posedge core_clk_i) disable iff (srst_i)
      cap_evt |-> (pol ? (in_s2_q && !in_prev_q) : (!in_s2_q && in_prev_q)))
      else $error("capture on wrong edge");
   a_cause_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
      cap_evt |=> ctl0_q[CTL0_CAP_CAUSE_BIT] && stat_q[IRQ_CAPTURE_BIT])
      else $error("capture cause not set");
   a_cause_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      reload_evt && is_capture && !cap_evt && !wr_ctl0
      |=> !ctl0_q[CTL0_CAP_CAUSE_BIT] && stat_q[IRQ_RELOAD_BIT])
      else $error("reload did not clear cause");
   a_prescale_field_reset: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !enable |=> pre_q == 7'h00)
      else $error("prescaler not reset when disabled");
   a_prescale_field_div: assert property (@(posedge core_clk_i) disable iff (srst_i)
      tick && prescale_field == 3'h1 && !wr_ctl1 ##1 !wr_ctl1 |-> !tick ##1 tick)
      else $error("divide by two wrong");
   a_hold_latch: assert property (@(posedge core_clk_i) disable iff (srst_i)
      rd_cnt_hi && enable |=> hold_q == $past(cnt_q[7:0]))
      else $error("low byte not latched");
   a_live_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
      rd_i && addr_i == ADDR_CNT_LO && !enable |=> rdata_o == $past(cnt_q[7:0]))
      else $error("disabled low read not live");
   a_byte_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
      wr_cnt_lo |=> cnt_q[7:0] == $past(wdata_i))
      else $error("count byte not loaded");
   a_restart: assert property (@(posedge core_clk_i) disable iff (srst_i)
      reload_evt && !wr_cnt_hi && !wr_cnt_lo |=> cnt_q == CNT_RESTART)
      else $error("no restart from one");
   a_pwm_level: assert property (@(posedge core_clk_i) disable iff (srst_i)
      enable && is_pwm && !pol && !wr_ctl1 |=> timer_out_o == !$past(below_pwm))
      else $error("pwm level wrong");
   a_pwm_high: assert property (@(posedge core_clk_i) disable iff (srst_i)
      enable && is_pwm && pol && !wr_ctl1 |=> timer_out_o == $past(below_pwm))
      else $error("pwm set polarity level wrong");
   a_out_rest: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !(enable && is_pwm) |=> timer_out_o == $past(pol))
      else $error("idle output not at polarity");
   a_hi_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
      wr_cnt_hi |=> cnt_q[15:8] == $past(wdata_i))
      else $error("count high byte not loaded");
   a_stat_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      wr_stat && wdata_i[IRQ_RELOAD_BIT] && !reload_evt
      |=> !stat_q[IRQ_RELOAD_BIT])
      else $error("reload status not cleared");
   a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !rd_i |=> rdata_o == 8'h00)
      else $error("read data not idle");
   c_capture: cover property (@(posedge core_clk_i) cap_evt);
   c_reload: cover property (@(posedge core_clk_i) reload_evt && is_capture);
   c_irq: cover property (@(posedge core_clk_i) irq_o);
   c_pwm_toggle: cover property (@(posedge core_clk_i) is_pwm && $rose(out_q));
endmodule // reload_timer
`default_nettype wire

// file: timer_pins_model.sv
// Far-side model of the timer pins: drives the input, watches the output
`timescale 1ns/100ps
`default_nettype none
module timer_pins_model (
   input wire logic core_clk_i,
   input wire logic timer_out_i,
   output logic timer_in_o
);
   int hi_cnt = 0;
   initial timer_in_o = 1'h0;
   // input rate: each level holds at least five clocks
   task automatic drive(input logic v);
      @(posedge core_clk_i);
      timer_in_o <= v;
      repeat (4) @(posedge core_clk_i);
   endtask
   // Count output high cycles so duty can be judged over whole periods
   always @(posedge core_clk_i) begin
      if (timer_out_i === 1'h1) begin
         hi_cnt <= hi_cnt + 1;
      end
   end
endmodule // timer_pins_model
`default_nettype wire

// file: tb_reload_timer_capture_pwm.sv
// Self-checking bench of the reloadable capture and PWM timer
`timescale 1ns/100ps
`default_nettype none
module tb_reload_timer_capture_pwm;
   import reload_timer_pkg::*;
   typedef struct {logic pol; logic [7:0] pwm; logic [7:0] rld; int hi;} row_t;
   logic core_clk = 1'h0;
   logic srst = 1'h1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [7:0] rdata;
   logic tin;
   logic tout;
   logic irq;
   logic [15:0] d;
   timer_mode_t m;
   int miscompares = 0;
   int total_checks = 0;
   int i;
   int k;
   // Duty rows: polarity, pwm, reload, high cycles per period
   row_t rows [4] = '{'{1'h0, 8'h02, 8'h08, 6}, '{1'h1, 8'h02, 8'h08, 2},
      '{1'h0, 8'h05, 8'h08, 3}, '{1'h1, 8'h07, 8'h08, 7}};
   reload_timer uut (.core_clk_i(core_clk), .srst_i(srst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .timer_in_i(tin), .timer_out_o(tout), .irq_o(irq));
   timer_pins_model pins (.core_clk_i(core_clk), .timer_out_i(tout),
      .timer_in_o(tin));
   initial begin
      forever #4 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge core_clk);
      wr <= 1'h0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge core_clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge core_clk);
      rd <= 1'h0;
      #1 v = {8'h00, rdata};
   endtask
   // setup order: disable, program, count, reload, pwm, then enable
   // count bytes are loaded here only while the timer is stopped
   task automatic setup(input logic [7:0] c0, input logic [7:0] c1,
      input logic [15:0] cnt, input logic [15:0] rld);
      wr_reg(ADDR_CTL1, 8'h00);
      wr_reg(ADDR_CTL0, c0);
      wr_reg(ADDR_CNT_HI, cnt[15:8]);
      wr_reg(ADDR_CNT_LO, cnt[7:0]);
      wr_reg(ADDR_RLD_HI, rld[15:8]);
      wr_reg(ADDR_RLD_LO, rld[7:0]);
      wr_reg(ADDR_PWM_HI, 8'h00);
      wr_reg(ADDR_PWM_LO, c1[2] ? 8'h00 : rows[k].pwm);
      wr_reg(ADDR_CTL1, c1);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Whole run is near 5.5k cycles; a hang is cut well beyond that
   initial begin
      repeat (50000) @(posedge core_clk);
      miscompares++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge core_clk);
      srst <= 1'h0;
      for (k = 0; k < 4; k++) begin
         setup(8'h00, {1'h1, rows[k].pol, 6'h03}, 16'h0001, {8'h00, rows[k].rld});
         repeat (24) @(posedge core_clk);
         i = pins.hi_cnt;
         repeat (4 * rows[k].rld) @(posedge core_clk);
         chk(16'(pins.hi_cnt - i), 16'(4 * rows[k].hi));
      end
      // Mid-run reset, then reset values and an unmapped address
      srst <= 1'h1;
      repeat (20) @(posedge core_clk);
      srst <= 1'h0;
      for (i = 0; i < 11; i++) begin
         rd_reg(i[3:0], d);
         chk(d, (i == 4 || i == 5) ? 16'h00FF : 16'h0000);
      end
      m = m.first();
      repeat (m.num()) begin
         wr_reg(ADDR_CTL0, {m[3], 7'h00});
         wr_reg(ADDR_CTL1, {5'h00, m[2:0]});
         rd_reg(ADDR_CTL0, d);
         chk(d, {8'h00, m[3], 7'h00});
         rd_reg(ADDR_CTL1, d);
         chk(d, {13'h0000, m[2:0]});
         m = m.next();
      end
      // Sixteen prescaled ticks per setting; restart after each disable
      for (k = 0; k < 8; k++) begin
         setup(8'h00, {2'h2, k[2:0], 3'h1}, 16'h0000, 16'hFFFF);
         repeat ((16 << k) - 2) @(posedge core_clk);
         wr_reg(ADDR_CTL1, 8'h00);
         rd_reg(ADDR_CNT_LO, d);
         chk({15'h0000, d >= 15 && d <= 18}, 16'h0001);
      end
      // Slow prescale so one tick falls between the high-byte read and the next low-byte read
      setup(8'h00, 8'hB9, 16'h10FF, 16'hFFFF);
      wr_reg(ADDR_CNT_HI, 8'h20);
      rd_reg(ADDR_CNT_HI, d);
      chk(d, 16'h0020);
      repeat (200) @(posedge core_clk);
      rd_reg(ADDR_CNT_LO, d);
      chk(d, 16'h00FF);
      wr_reg(ADDR_CTL1, 8'h00);
      rd_reg(ADDR_CNT_LO, d);
      chk(d, 16'h0000);
      rd_reg(ADDR_CNT_HI, d);
      chk(d, 16'h0021);
      // Capture on each polarity: wrong edge first, then the right one
      for (k = 0; k < 2; k++) begin
         pins.drive(k[0]);
         wr_reg(ADDR_IRQ_MASK, 8'h03);
         wr_reg(ADDR_IRQ_STAT, 8'h03);
         setup(8'h00, {1'h1, k[0], 6'h04}, 16'h0001, 16'h0100);
         pins.drive(~k[0]);
         rd_reg(ADDR_IRQ_STAT, d);
         chk(d, 16'h0000);
         pins.drive(k[0]);
         chk(irq, 1'h1);
         rd_reg(ADDR_CTL0, d);
         chk(d, 16'h0010);
         rd_reg(ADDR_PWM_LO, d);
         chk({15'h0000, d >= 10 && d <= 22}, 16'h0001);
         wr_reg(ADDR_IRQ_STAT, 8'h02);
         #1 chk(irq, 1'h0);
         for (i = 0; i < 300 && irq !== 1'h1; i++) @(posedge core_clk);
         chk(irq, 1'h1);
         rd_reg(ADDR_CNT_HI, d);
         rd_reg(ADDR_CNT_LO, d);
         chk({15'h0000, d >= 1 && d <= 9}, 16'h0001);
         rd_reg(ADDR_CTL0, d);
         chk(d, 16'h0000);
         wr_reg(ADDR_IRQ_MASK, 8'h00);
         #1 chk(irq, 1'h0);
      end
      test_done();
   end
endmodule // tb_reload_timer_capture_pwm
`default_nettype wire
